// [rtl/eps_defines.svh]
// Purpose: Offsets, field positions and reset values of the strobe port
// Assumes: ISA I/O index/data pair at 3E0h/3E1h
// Notes:   Definitions only
`ifndef EPS_DEFINES_SVH
`define EPS_DEFINES_SVH

// ****************************************************************
// ISA locations and indices
// ****************************************************************
`define EPS_ADDR_INDEX   10'h3E0
`define EPS_ADDR_DATA    10'h3E1
`define EPS_IDX_A_EXT    8'h2E
`define EPS_IDX_A_REG    8'h2F
`define EPS_IDX_B_EXT    8'h6E
`define EPS_IDX_B_REG    8'h6F
`define EPS_EXT_DATA     8'h0A
`define EPS_EXT_CTRL     8'h0B

// ****************************************************************
// Strobe control fields
// ****************************************************************
`define EPS_BIT_ACT_HIGH 5
`define EPS_BIT_WR_STB   4
`define EPS_BIT_RD_STB   3
`define EPS_BIT_PUSH     2
`define EPS_CTRL_MASK    8'h3C
`define EPS_CTRL_RST     8'h00
`define EPS_DATA_RST     8'h00
`define EPS_IDX_RST      8'h00

`endif

// [rtl/eps_pkg.sv]
// Purpose: Shared types of the strobe port
// Assumes: Two sockets
// Notes:   Constants live in eps_defines.svh
package eps_pkg;
  typedef logic [7:0] eps_byte_type;
  typedef logic [9:0] eps_addr_type;
  typedef enum logic [1:0] {
    EPS_MODE_INPUT,
    EPS_MODE_READ,
    EPS_MODE_WRITE,
    EPS_MODE_BOTH
  } eps_mode_type;
endpackage

// [rtl/eps_sock_if.sv]
// Purpose: Register traffic between the decoder and one socket store
// Assumes: One instance per socket
// Notes:   Write strobes are one-cycle pulses
`timescale 1ns/10ps
interface eps_sock_if;
  import eps_pkg::*;
  logic         wr_ext;
  logic         wr_ctrl;
  logic         wr_shadow;
  eps_byte_type wdata;
  eps_byte_type ext_idx;
  eps_byte_type ctrl;
  eps_byte_type shadow;
  modport store (input wr_ext, wr_ctrl, wr_shadow, wdata, output ext_idx, ctrl, shadow);
  modport user  (output wr_ext, wr_ctrl, wr_shadow, wdata, input ext_idx, ctrl, shadow);
endinterface

// [rtl/eps_sock_store.sv]
// Purpose: Per-socket extended index, strobe control and data shadow
// Assumes: Writes arrive as one-cycle pulses on mclk
// Notes:   Reserved control bits are never stored
`timescale 1ns/10ps
`include "eps_defines.svh"
module eps_sock_store (
  // Clock and reset
  input wire logic  mclk,
  input wire logic  sys_rst,
  // Register traffic
  eps_sock_if.store port
);
  import eps_pkg::*;

  eps_byte_type ext_idx_reg;
  eps_byte_type ctrl_reg;
  eps_byte_type shadow_reg;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_idx_reg <= `EPS_IDX_RST;
    end else if (port.wr_ext) begin
      ext_idx_reg <= port.wdata;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= `EPS_CTRL_RST;
    end else if (port.wr_ctrl) begin
      // Stray scratch bits would alter nothing, so they are dropped
      ctrl_reg <= port.wdata & `EPS_CTRL_MASK;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      shadow_reg <= `EPS_DATA_RST;
    end else if (port.wr_shadow) begin
      shadow_reg <= port.wdata;
    end
  end

  assign port.ext_idx = ext_idx_reg;
  assign port.ctrl    = ctrl_reg;
  assign port.shadow  = shadow_reg;
endmodule

// [rtl/eps_top.sv]
// Purpose: ISA-mapped general-purpose strobe ports for two sockets
// Assumes: ISA pins sampled on mclk; strobe path is clockless
// Notes:   Strobe pins follow IOR*/IOW* without a clock by design
`timescale 1ns/10ps
`include "eps_defines.svh"
module eps_top (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  // ISA bus
  input  wire eps_pkg::eps_addr_type isa_addr,
  input  wire logic          isa_aen,
  input  wire logic          isa_ior_n,
  input  wire logic          isa_iow_n,
  input  wire eps_pkg::eps_byte_type isa_sd_in,
  output      eps_pkg::eps_byte_type isa_sd_out,
  output      logic          isa_sd_oe,
  // Power state
  input  wire logic          suspend,
  // Socket pull-up control bits
  input  wire logic [1:0]    pullup_ctl,
  // Socket A strobe pin
  output      logic          socket_a_strobe_out,
  output      logic          socket_a_strobe_oe,
  output      logic          socket_a_pullup_en,
  // Socket B strobe pin
  output      logic          socket_b_strobe_out,
  output      logic          socket_b_strobe_oe,
  output      logic          socket_b_pullup_en
);
  import eps_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic eps_mode_type mode_of(input eps_byte_type ctrl);
    unique case ({ctrl[`EPS_BIT_WR_STB], ctrl[`EPS_BIT_RD_STB]})
      2'b00: mode_of = EPS_MODE_INPUT;
      2'b01: mode_of = EPS_MODE_READ;
      2'b10: mode_of = EPS_MODE_WRITE;
      2'b11: mode_of = EPS_MODE_BOTH;
    endcase
  endfunction

  function automatic eps_byte_type ext_idx_of(input logic sock);
    ext_idx_of = sock ? `EPS_IDX_B_EXT : `EPS_IDX_A_EXT;
  endfunction

  function automatic eps_byte_type reg_idx_of(input logic sock);
    reg_idx_of = sock ? `EPS_IDX_B_REG : `EPS_IDX_A_REG;
  endfunction

  // ****************************************************************
  // ISA cycle tracking
  // ****************************************************************
  eps_byte_type index_reg;
  logic         iow_q_reg;
  logic         wr_start;
  logic         at_index;
  logic         at_data;
  logic         super_susp;

  assign at_index   = !isa_aen && (isa_addr == `EPS_ADDR_INDEX);
  assign at_data    = !isa_aen && (isa_addr == `EPS_ADDR_DATA);
  // Data is taken on the falling edge of IOW* where SD is already valid
  assign wr_start   = iow_q_reg && !isa_iow_n;
  assign super_susp = suspend && isa_aen;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      iow_q_reg <= 1'b1;
    end else begin
      iow_q_reg <= isa_iow_n;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      index_reg <= `EPS_IDX_RST;
    end else if (wr_start && at_index) begin
      index_reg <= isa_sd_in;
    end
  end

  // ****************************************************************
  // Per-socket stores and strobe logic
  // ****************************************************************
  logic         stb_level [2];
  logic         stb_oe    [2];
  logic         pu_next   [2];
  logic         hit_data  [2];
  logic         hit_ext   [2];
  logic         reads_ext [2];
  eps_byte_type rd_val    [2];
  logic         rd_own    [2];

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_sock
      eps_sock_if   sif ();
      eps_mode_type mode;
      logic         sel_port;
      logic         active;

      eps_sock_store u_store (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .port    (sif.store)
      );

      assign mode        = mode_of(sif.ctrl);
      assign hit_ext[s]  = at_data && (index_reg == ext_idx_of(s[0]));
      assign hit_data[s] = at_data && (index_reg == reg_idx_of(s[0]));
      // Address, index and extended index must all agree
      assign sel_port    = hit_data[s] && (sif.ext_idx == `EPS_EXT_DATA);

      assign sif.wdata     = isa_sd_in;
      assign sif.wr_ext    = wr_start && hit_ext[s];
      assign sif.wr_ctrl   = wr_start && hit_data[s] && (sif.ext_idx == `EPS_EXT_CTRL);
      // Clock is gone in suspend, so no shadow capture then
      assign sif.wr_shadow = wr_start && sel_port && !suspend;

      // Purely combinational path; no mclk edge is needed for a strobe
      always_comb begin
        active = 1'b0;
        if (sel_port && !super_susp) begin
          if (sif.ctrl[`EPS_BIT_WR_STB] && !isa_iow_n) begin
            active = 1'b1;
          end
          if (sif.ctrl[`EPS_BIT_RD_STB] && !isa_ior_n) begin
            active = 1'b1;
          end
        end
      end

      // Idle level is the opposite of the active level
      assign stb_level[s] = sif.ctrl[`EPS_BIT_ACT_HIGH] ? active : !active;

      always_comb begin
        if (mode == EPS_MODE_INPUT) begin
          stb_oe[s] = 1'b0;
        end else if (sif.ctrl[`EPS_BIT_PUSH]) begin
          stb_oe[s] = 1'b1;
        end else begin
          stb_oe[s] = !stb_level[s];
        end
      end

      assign pu_next[s] = (mode == EPS_MODE_INPUT) && !pullup_ctl[s];

      // External buffer drives SD when read strobe is on
      assign reads_ext[s] = sel_port && sif.ctrl[`EPS_BIT_RD_STB];

      always_comb begin
        rd_own[s] = 1'b0;
        rd_val[s] = 8'h00;
        if (hit_ext[s]) begin
          rd_own[s] = 1'b1;
          rd_val[s] = sif.ext_idx;
        end else if (hit_data[s]) begin
          rd_own[s] = !reads_ext[s];
          if (sif.ext_idx == `EPS_EXT_CTRL) begin
            rd_val[s] = sif.ctrl;
          end else if (sif.ext_idx == `EPS_EXT_DATA) begin
            rd_val[s] = sif.shadow;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Pins
  // ****************************************************************
  // Strobe pins bypass flip-flops: a registered strobe could not
  // track IOR*/IOW* exactly nor run with the clock stopped
  assign socket_a_strobe_out = stb_level[0];
  assign socket_a_strobe_oe  = stb_oe[0];
  assign socket_b_strobe_out = stb_level[1];
  assign socket_b_strobe_oe  = stb_oe[1];

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      socket_a_pullup_en <= 1'b1;
      socket_b_pullup_en <= 1'b1;
    end else begin
      socket_a_pullup_en <= pu_next[0];
      socket_b_pullup_en <= pu_next[1];
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      isa_sd_out <= 8'h00;
      isa_sd_oe  <= 1'b0;
    end else if (!isa_ior_n) begin
      if (at_index) begin
        isa_sd_out <= index_reg;
        isa_sd_oe  <= 1'b1;
      end else if (rd_own[0]) begin
        isa_sd_out <= rd_val[0];
        isa_sd_oe  <= 1'b1;
      end else if (rd_own[1]) begin
        isa_sd_out <= rd_val[1];
        isa_sd_oe  <= 1'b1;
      end else begin
        isa_sd_out <= 8'h00;
        isa_sd_oe  <= 1'b0;
      end
    end else begin
      isa_sd_oe <= 1'b0;
    end
  end
endmodule

// [verification/eps_properties.sv]
// Purpose: Port-level checks of the strobe port
// Assumes: One mclk domain
// Notes:   Bound to eps_top
`timescale 1ns/10ps
module eps_properties (
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  // ISA bus
  input wire eps_pkg::eps_addr_type isa_addr,
  input wire logic                  isa_aen,
  input wire logic                  isa_ior_n,
  input wire logic                  isa_iow_n,
  input wire eps_pkg::eps_byte_type isa_sd_in,
  input wire eps_pkg::eps_byte_type isa_sd_out,
  input wire logic                  isa_sd_oe,
  // Power and pull-up control
  input wire logic                  suspend,
  input wire logic [1:0]            pullup_ctl,
  // Strobe pins
  input wire logic                  socket_a_strobe_out,
  input wire logic                  socket_a_strobe_oe,
  input wire logic                  socket_a_pullup_en,
  input wire logic                  socket_b_strobe_out,
  input wire logic                  socket_b_strobe_oe,
  input wire logic                  socket_b_pullup_en
);
  import eps_pkg::*;
  logic [1:0] stb;
  assign stb = {socket_a_strobe_out, socket_b_strobe_out};
  // ****
  // Checks
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_idx_read;
    !isa_aen && !isa_ior_n && isa_addr == 10'h3E0;
  endsequence
  // Three quiet samples so a control update never counts as a strobe
  sequence s_quiet;
    (isa_ior_n && isa_iow_n) [*3];
  endsequence
  a_index_read: assert property (s_idx_read |=> isa_sd_oe)
    else $error("index read not answered");
  a_read_release: assert property ($rose(isa_ior_n) |=> !isa_sd_oe)
    else $error("data bus held after read");
  a_aen_silent: assert property (isa_aen [*2] |-> !isa_sd_oe)
    else $error("data bus driven with aen high");
  a_strobe_rest: assert property (s_quiet |-> $stable(stb))
    else $error("strobe moved without a bus access");
  a_super_quiet: assert property ((isa_aen && suspend) [*2] |-> $stable(stb))
    else $error("strobe moved in super-suspend");
  a_pu_ctl_a: assert property (pullup_ctl[0] |=> !socket_a_pullup_en)
    else $error("pull-up a left on");
  a_pu_ctl_b: assert property (pullup_ctl[1] |=> !socket_b_pullup_en)
    else $error("pull-up b left on");
  a_pu_strobe_a: assert property (socket_a_strobe_oe [*2] |-> !socket_a_pullup_en)
    else $error("pull-up a on while driving");
  a_pu_strobe_b: assert property (socket_b_strobe_oe [*2] |-> !socket_b_pullup_en)
    else $error("pull-up b on while driving");
endmodule
bind eps_top eps_properties u_props (.*);

// [verification/eps_ext_port.sv]
// Purpose: External latch or buffer on one strobe pin
// Assumes: Latch takes SD[7:0] as the strobe ends
// Notes:   Buffer data is not routed back to the bus
`timescale 1ns/10ps
module eps_ext_port (
  // Power and pin
  input wire logic       pwr_good,
  input wire logic       pin,
  input wire logic       act_high,
  input wire logic       wr_port,
  // Data side
  input wire logic [7:0] sd,
  output     logic [7:0] latch_q,
  output     logic       buf_oe
);
  wire active = (pin == act_high);
  assign buf_oe = active && !wr_port;
  // Cleared by power-good so outputs show zeros after reset
  always @(negedge active or negedge pwr_good) begin
    if (!pwr_good)
      latch_q <= 8'h00;
    else if (wr_port)
      latch_q <= sd;
  end
endmodule

// [verification/tb_top.sv]
// Purpose: Self-checking bench of the two-socket strobe port
// Assumes: 20 MHz mclk, index/data pair at 3E0h/3E1h
// Notes:   Undriven pins read high through the board pull-up
`timescale 1ns/10ps
module tb_top;
  import eps_pkg::*;
  logic         mclk, sys_rst, isa_aen, isa_ior_n, isa_iow_n, isa_sd_oe, suspend;
  logic [1:0]   pullup_ctl;
  eps_addr_type isa_addr;
  eps_byte_type isa_sd_in, isa_sd_out, q, lq_a, lq_b;
  logic         socket_a_strobe_out, socket_a_strobe_oe, socket_a_pullup_en;
  logic         socket_b_strobe_out, socket_b_strobe_oe, socket_b_pullup_en;
  logic         roe, pa, pb, bo_a, bo_b, pol_a, ob;
  int           errors, n_checks, cyc;
  wire          pin_a = socket_a_strobe_oe ? socket_a_strobe_out : 1'b1;
  wire          pin_b = socket_b_strobe_oe ? socket_b_strobe_out : 1'b1;
  eps_top uut (.*);
  eps_ext_port ma (.pwr_good(!sys_rst), .pin(pin_a), .act_high(pol_a), .wr_port(1'b1),
                   .sd(isa_sd_in), .latch_q(lq_a), .buf_oe(bo_a));
  eps_ext_port mb (.pwr_good(!sys_rst), .pin(pin_b), .act_high(1'b0), .wr_port(1'b0),
                   .sd(isa_sd_in), .latch_q(lq_b), .buf_oe(bo_b));
  // ****
  // Clock, timeout and helpers
  // ****
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bchk(input string n, input logic e, input logic g);
    chk(n, {7'h00, e}, {7'h00, g});
  endtask
  // Pins sampled while the strobe is low, read data after the answer edge
  task automatic acc(input logic rd, input eps_addr_type a, input eps_byte_type d);
    @(posedge mclk);
    isa_addr <= a;
    isa_sd_in <= d;
    isa_ior_n <= !rd;
    isa_iow_n <= rd;
    @(posedge mclk);
    #1;
    pa = pin_a;
    pb = pin_b;
    ob = bo_b;
    @(posedge mclk);
    isa_ior_n <= 1'b1;
    isa_iow_n <= 1'b1;
    #1;
    q = isa_sd_out;
    roe = isa_sd_oe;
    @(posedge mclk);
  endtask
  task automatic wr(input eps_addr_type a, input eps_byte_type d);
    acc(1'b0, a, d);
  endtask
  task automatic rd();
    acc(1'b1, 10'h3E1, 8'h00);
  endtask
  task automatic sel(input logic s, input eps_byte_type e);
    wr(10'h3E0, s ? 8'h6E : 8'h2E);
    wr(10'h3E1, e);
    wr(10'h3E0, s ? 8'h6F : 8'h2F);
  endtask
  task automatic setc(input logic s, input eps_byte_type c);
    sel(s, 8'h0B);
    wr(10'h3E1, c);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    bchk("pullup_a", 1'b1, socket_a_pullup_en);
    setc(1'b1, 8'h3C);
    rd();
    chk("ctrl_b", 8'h3C, q);
    sel(1'b0, 8'h0B);
    rd();
    chk("ctrl_a", 8'h00, q);
    acc(1'b1, 10'h3E0, 8'h00);
    chk("index", 8'h2F, q);
    setc(1'b1, 8'h00);
  endtask
  task automatic t_write();
    setc(1'b0, 8'h10);
    sel(1'b0, 8'h0A);
    wr(10'h3E1, 8'hA5);
    bchk("wr_strobe", 1'b0, pa);
    bchk("other_pin", 1'b1, pb);
    bchk("pin_idle", 1'b1, pin_a);
    chk("latch", 8'hA5, lq_a);
    bchk("pullup_off", 1'b0, socket_a_pullup_en);
    rd();
    bchk("no_rd_strobe", 1'b1, pa);
    chk("shadow", 8'hA5, q);
    bchk("sd_drive", 1'b1, roe);
  endtask
  task automatic t_push();
    pol_a = 1'b1;
    setc(1'b0, 8'h34);
    bchk("pp_drive", 1'b1, socket_a_strobe_oe);
    bchk("idle_low", 1'b0, socket_a_strobe_out);
    sel(1'b0, 8'h0A);
    wr(10'h3E1, 8'h5A);
    bchk("act_high", 1'b1, pa);
    chk("latch_hi", 8'h5A, lq_a);
  endtask
  task automatic t_read();
    setc(1'b1, 8'h08);
    sel(1'b1, 8'h0A);
    wr(10'h3E1, 8'h3C);
    bchk("rd_mode_wr", 1'b1, pb);
    rd();
    bchk("rd_strobe", 1'b0, pb);
    bchk("not_driven", 1'b0, roe);
    bchk("buf_on", 1'b1, ob);
    chk("latch_b", 8'h00, lq_b);
    setc(1'b1, 8'h10);
    sel(1'b1, 8'h0A);
    rd();
    chk("hidden", 8'h3C, q);
  endtask
  task automatic t_susp();
    sel(1'b0, 8'h0A);
    @(posedge mclk);
    suspend <= 1'b1;
    wr(10'h3E1, 8'h77);
    bchk("susp_strobe", 1'b1, pa);
    chk("susp_latch", 8'h77, lq_a);
    @(posedge mclk);
    isa_aen <= 1'b1;
    wr(10'h3E1, 8'h99);
    bchk("super_block", 1'b0, pa);
    @(posedge mclk);
    isa_aen <= 1'b0;
    suspend <= 1'b0;
    rd();
    chk("no_shadow", 8'h5A, q);
  endtask
  task automatic t_pull();
    setc(1'b1, 8'h00);
    bchk("input_pu", 1'b1, socket_b_pullup_en);
    sel(1'b1, 8'h0A);
    wr(10'h3E1, 8'h11);
    bchk("a_quiet", 1'b0, pa);
    chk("a_kept", 8'h77, lq_a);
    pullup_ctl <= 2'b11;
    repeat (2) @(posedge mclk);
    bchk("pu_ctl", 1'b0, socket_b_pullup_en);
  endtask
  initial begin
    sys_rst = 1'b1;
    isa_aen = 1'b0;
    isa_ior_n = 1'b1;
    isa_iow_n = 1'b1;
    isa_addr = 10'h000;
    isa_sd_in = 8'h00;
    suspend = 1'b0;
    pullup_ctl = 2'b00;
    pol_a = 1'b0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs();
    t_write();
    t_push();
    t_read();
    t_susp();
    t_pull();
    conclude();
  end
endmodule
